// File: hw/qec_top.sv
`timescale 1ns/10ps
// Contract
// (R1) Modes 100/101 count both phase A edges
// (R2) x2: 100 index reset, 101 max reset
// (R3) Modes 110/111 count all A, B edges
// (R4) x4: 110 index reset, 111 max reset
// (R5) Phase B sets each edge's direction
// (R6) Mode field at control bits 10:8
// (R7) Filter output changes after three stable samples
// (R8) Filter clock divided by filter bits 6:4
// (R9) Filtered inputs used only when enable set
// (R10) Power-on/brown-out reset disables the filters
// (R11) Mode 001 makes 16-bit timer from phase A
// (R12) Timer: position=count, max=period, match sets flag
// (R13) Timer counts to period, then returns zero
// (R14) Direction bit 1 counts up, 0 down
// (R15) Source bit picks phase B or direction bit
// (R16) Mode switches keep the count unchanged
// (R17) Phase A clock synchronised before counting
// (R18) Encoder counting halts during sleep
// (R19) Timer does not advance during sleep
// (R20) A leading B counts up, else down
module qec_top
    import qec_pkg::*;
(
    input wire logic clk_i, // 200 MHz instruction clock
    input wire logic rst_i, // Synchronous, active high
    input wire logic ce_i, // Low freezes every flip-flop
    input wire logic sleep_i, // CPU sleep indication
    input wire logic por_bor_i, // Power-on or brown-out reset event
    input wire logic phase_a_in_i, // Encoder phase A pin
    input wire logic phase_b_in_i, // Encoder phase B pin
    input wire logic index_in_i, // Encoder index pin
    input wire logic [7:0] adr_i, // Wishbone byte address
    input wire logic [31:0] dat_i, // Wishbone write data
    input wire logic [3:0] sel_i, // Wishbone byte selects
    input wire logic we_i, // Wishbone write enable
    input wire logic cyc_i, // Wishbone cycle
    input wire logic stb_i, // Wishbone strobe
    output logic [31:0] dat_o, // Wishbone read data
    output logic ack_o, // Wishbone acknowledge
    output logic match_flag_o, // Sticky count/period flag
    output logic [15:0] position_o // Current position count
);

    // ==========================================================
    // Registers
    logic [15:0] encoder_control_reg_q; // Mode, direction, source
    logic [15:0] filter_control_reg_q; // Divider and output enable
    logic [15:0] position_count_reg_q; // Position or timer count
    logic [15:0] position_count_reg_d;
    logic [15:0] max_count_reg_q; // Maximum count or period
    logic flag_q; // Sticky match flag
    logic dir_q; // Last counting direction, 1 = up
    logic ack_q; // Bus acknowledge
    logic [31:0] rdata_q; // Registered read data

    // Decoded fields
    qec_mode_t mode; // see (R6)
    logic [2:0] filter_clock_div;
    logic filter_out_en;
    logic count_dir;
    logic count_dir_source;

    assign mode = qec_mode_t'(encoder_control_reg_q[`QEC_CTRL_MODE_HI:`QEC_CTRL_MODE_LO]);
    assign filter_clock_div = filter_control_reg_q[`QEC_FILT_DIV_HI:`QEC_FILT_DIV_LO];
    assign filter_out_en = filter_control_reg_q[`QEC_FILT_OUTEN_BIT];
    assign count_dir = encoder_control_reg_q[`QEC_CTRL_DIR_BIT];
    assign count_dir_source = encoder_control_reg_q[`QEC_CTRL_DSRC_BIT];

    // Bus request decode
    // A request is taken only while ack is low, so a strobe that is
    // still held in the ack cycle is not answered twice
    logic bus_req;
    logic wr_ctrl, wr_filt, wr_pos, wr_max, wr_stat;
    assign bus_req = cyc_i && stb_i && !ack_q;
    assign wr_ctrl = bus_req && we_i && (adr_i == `QEC_ADR_CTRL);
    assign wr_filt = bus_req && we_i && (adr_i == `QEC_ADR_FILT);
    assign wr_pos = bus_req && we_i && (adr_i == `QEC_ADR_POS);
    assign wr_max = bus_req && we_i && (adr_i == `QEC_ADR_MAX);
    assign wr_stat = bus_req && we_i && (adr_i == `QEC_ADR_STAT);

    // Byte-lane merge of a 16-bit register with write data
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = wd[7:0];
        end
        if (sel[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    // ==========================================================
    // Input synchronisers and noise filters
    logic [2:0] pin_raw; // index, B, A
    logic [2:0] sync1_q; // First stage, read only by second
    logic [2:0] sync2_q; // Synchronised pins
    logic [2:0] filt_q; // Filtered pins
    logic [2:0] pin_sel; // Pins chosen for counting
    logic [7:0] div_cnt_q; // Filter clock divider
    logic filt_tick; // One filter clock
    assign pin_raw = {index_in_i, phase_b_in_i, phase_a_in_i};

    // Two-stage synchroniser; phase A used as timer clock passes here too
    always_ff @(posedge clk_i) begin // see (R17)
        if (rst_i) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else if (ce_i) begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end

    // Filter clock is the instruction clock divided by 2^field
    always_ff @(posedge clk_i) begin // see (R8)
        if (rst_i) begin
            div_cnt_q <= 8'h00;
        end else if (ce_i) begin
            if (filt_tick) begin
                div_cnt_q <= 8'h00;
            end else begin
                div_cnt_q <= div_cnt_q + 8'h01;
            end
        end
    end
    assign filt_tick = (div_cnt_q == 8'((9'h001 << filter_clock_div) - 9'h001)); // see (R8)

    // Per-channel stability filter
    // Filters run even while bypassed, so enabling the output later
    // shows already settled pins instead of a false edge
    for (genvar g = 0; g < 3; g++) begin : g_filt
        logic last_q; // Previous filter sample
        logic [1:0] run_q; // Consecutive equal samples
        logic [1:0] run_d;
        always_comb begin
            run_d = 2'h1;
            if (sync2_q[g] == last_q) begin
                run_d = (run_q == `QEC_FILT_STABLE) ? run_q : run_q + 2'h1;
            end
        end
        // Output moves only after three equal samples in a row
        always_ff @(posedge clk_i) begin // see (R7)
            if (rst_i) begin
                last_q <= 1'b0;
                run_q <= 2'h0;
                filt_q[g] <= 1'b0;
            end else if (ce_i && filt_tick) begin
                last_q <= sync2_q[g];
                run_q <= run_d;
                if (run_d == `QEC_FILT_STABLE) begin
                    filt_q[g] <= sync2_q[g];
                end
            end
        end
    end

    // Bypass the filter unless its output is enabled
    assign pin_sel = filter_out_en ? filt_q : sync2_q; // see (R9)

    // ==========================================================
    // Edge and direction detection
    logic [2:0] prev_q; // Chosen pins one cycle ago
    // Resets to the idle low level of the pins, so that no false
    // edge is counted right after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= 3'h0;
        end else if (ce_i) begin
            prev_q <= pin_sel;
        end
    end

    logic a_edge, b_edge, a_rise, idx_rise;
    logic quad_up; // Quadrature direction
    logic is_x2, is_x4, is_qei, use_max;
    assign a_edge = pin_sel[0] ^ prev_q[0];
    assign b_edge = pin_sel[1] ^ prev_q[1];
    assign a_rise = pin_sel[0] && !prev_q[0];
    assign idx_rise = pin_sel[2] && !prev_q[2];
    // A leading B: new A differs from old B
    assign quad_up = pin_sel[0] ^ prev_q[1]; // see (R5) see (R20)
    assign is_x2 = (mode == QEC_X2_IDX) || (mode == QEC_X2_MAX); // see (R1)
    assign is_x4 = (mode == QEC_X4_IDX) || (mode == QEC_X4_MAX); // see (R3)
    assign is_qei = is_x2 || is_x4;
    assign use_max = (mode == QEC_X2_MAX) || (mode == QEC_X4_MAX); // see (R2) see (R4)

    // Counting events
    logic qei_step; // Encoder edge to count
    logic tmr_step; // Timer clock edge
    logic tmr_up; // Timer direction
    assign qei_step = !sleep_i && ((is_x2 && a_edge) || (is_x4 && (a_edge || b_edge))); // see (R18)
    assign tmr_step = !sleep_i && (mode == QEC_TIMER) && a_rise; // see (R11) see (R19)
    assign tmr_up = count_dir_source ? pin_sel[1] : count_dir; // see (R14) see (R15)

    // ==========================================================
    // Position / timer count next value
    logic step, up, idx_reset, at_max, at_zero, wrap_evt;
    assign step = qei_step || tmr_step;
    assign up = tmr_step ? tmr_up : quad_up;
    assign idx_reset = is_qei && !use_max && idx_rise && !sleep_i; // see (R2) see (R4)
    assign at_max = (position_count_reg_q == max_count_reg_q);
    assign at_zero = (position_count_reg_q == 16'h0000);
    // Max-match wrap in encoder max modes and in timer mode
    assign wrap_evt = step && (tmr_step || use_max) && (up ? at_max : at_zero);

    always_comb begin
        position_count_reg_d = position_count_reg_q; // Mode change keeps value, see (R16)
        if (idx_reset) begin
            position_count_reg_d = 16'h0000; // see (R2) see (R4)
        end else if (wrap_evt) begin
            // Up returns to zero, down reloads the period
            position_count_reg_d = up ? 16'h0000 : max_count_reg_q; // see (R13)
        end else if (step) begin
            position_count_reg_d = up ? position_count_reg_q + 16'h0001
                                      : position_count_reg_q - 16'h0001;
        end
    end

    // Software write loses to nothing: it is the last word on the count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            position_count_reg_q <= `QEC_POS_RST;
        end else if (ce_i) begin
            if (wr_pos) begin
                position_count_reg_q <= merge16(position_count_reg_q, dat_i, sel_i);
            end else begin
                position_count_reg_q <= position_count_reg_d;
            end
        end
    end

    // Remember the direction of the last counted edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_q <= 1'b0;
        end else if (ce_i && step) begin
            dir_q <= up;
        end
    end

    // Sticky match flag; a set in the clear cycle wins
    always_ff @(posedge clk_i) begin // see (R12)
        if (rst_i) begin
            flag_q <= 1'b0;
        end else if (ce_i) begin
            if (tmr_step && wrap_evt) begin
                flag_q <= 1'b1;
            end else if (wr_stat && sel_i[0] && dat_i[`QEC_STAT_FLAG_BIT]) begin
                flag_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Control registers
    // Mode changes here never touch the count register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            encoder_control_reg_q <= `QEC_CTRL_RST;
        end else if (ce_i && wr_ctrl) begin
            encoder_control_reg_q <= merge16(encoder_control_reg_q, dat_i, sel_i);
        end
    end

    // Power-on or brown-out reset turns the filter output off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            filter_control_reg_q <= `QEC_FILT_RST;
        end else if (ce_i) begin
            if (por_bor_i) begin
                filter_control_reg_q <= `QEC_FILT_RST; // see (R10)
            end else if (wr_filt) begin
                filter_control_reg_q <= merge16(filter_control_reg_q, dat_i, sel_i);
            end
        end
    end

    // Maximum count or period; all ones after reset, so a fresh max
    // mode does not wrap early
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            max_count_reg_q <= `QEC_MAX_RST;
        end else if (ce_i && wr_max) begin
            max_count_reg_q <= merge16(max_count_reg_q, dat_i, sel_i);
        end
    end

    // ==========================================================
    // Wishbone answer: ack one cycle after the request, then drops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_q <= bus_req;
            if (bus_req) begin
                // Unmapped addresses read zero and are still acknowledged
                case (adr_i)
                    `QEC_ADR_CTRL: rdata_q <= {16'h0000, encoder_control_reg_q};
                    `QEC_ADR_FILT: rdata_q <= {16'h0000, filter_control_reg_q};
                    `QEC_ADR_POS: rdata_q <= {16'h0000, position_count_reg_q};
                    `QEC_ADR_MAX: rdata_q <= {16'h0000, max_count_reg_q};
                    `QEC_ADR_STAT: rdata_q <= {30'h0000_0000, dir_q, flag_q};
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign ack_o = ack_q;
    assign dat_o = rdata_q;
    assign match_flag_o = flag_q;
    assign position_o = position_count_reg_q;

    // ==========================================================
    // Checks
    // Decode held against literal bit positions, not the field macros
    chk_mode_field: assert property (@(posedge clk_i) disable iff (rst_i) // see (R6)
        (is_x2 == (encoder_control_reg_q[10:9] == 2'h2))
        && (is_x4 == (encoder_control_reg_q[10:9] == 2'h3))
        && ((mode == QEC_TIMER) == (encoder_control_reg_q[10:8] == 3'h1)))
        else $error("mode decode does not follow control bits 10:8");

    chk_x2_b_only: assert property (@(posedge clk_i) disable iff (rst_i) // see (R1)
        (ce_i && is_x2 && !a_edge && !idx_rise && !wr_pos) |=>
            $stable(position_count_reg_q))
        else $error("x2 count moved without a phase A edge");

    chk_x4_counts: assert property (@(posedge clk_i) disable iff (rst_i) // see (R3)
        (ce_i && is_x4 && !sleep_i && b_edge && !a_edge && !wr_pos && !idx_reset
         && !wrap_evt) |=> !$stable(position_count_reg_q))
        else $error("x4 missed a phase B edge");

    chk_index_clear: assert property (@(posedge clk_i) disable iff (rst_i) // see (R2)
        (ce_i && idx_reset && !wr_pos) |=> (position_count_reg_q == 16'h0000))
        else $error("index pulse did not clear the count");

    chk_quad_dir: assert property (@(posedge clk_i) disable iff (rst_i) // see (R20)
        (ce_i && qei_step && !idx_reset && !wrap_evt && !wr_pos
         && (pin_sel[0] != prev_q[1])) |=>
            (position_count_reg_q == $past(position_count_reg_q) + 16'h0001))
        else $error("A leading B did not count up");

    chk_tmr_wrap: assert property (@(posedge clk_i) disable iff (rst_i) // see (R13)
        (ce_i && tmr_step && tmr_up && at_max && !wr_pos) |=>
            (position_count_reg_q == 16'h0000) && flag_q)
        else $error("timer did not wrap to zero and flag");

    chk_sleep_hold: assert property (@(posedge clk_i) disable iff (rst_i) // see (R18)
        (sleep_i && !wr_pos) |=> $stable(position_count_reg_q))
        else $error("count moved during sleep");

    chk_filt_off: assert property (@(posedge clk_i) disable iff (rst_i) // see (R10)
        (ce_i && por_bor_i) |=> !filter_out_en)
        else $error("filter still enabled after power-on reset");

    chk_filt_stable: assert property (@(posedge clk_i) disable iff (rst_i) // see (R7)
        (ce_i && filt_tick && (filt_q[0] != sync2_q[0]) && (g_filt[0].run_q != 2'h2)
         && !(g_filt[0].run_q == 2'h3)) |=> $stable(filt_q[0]))
        else $error("filter changed before three stable samples");

    chk_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
        else $error("ack not given for exactly one cycle");

    // Main scenarios that the bench is expected to reach
    cov_x4_up: cover property (@(posedge clk_i) disable iff (rst_i) is_x4 && qei_step && up);
    cov_x2_down: cover property (@(posedge clk_i) disable iff (rst_i) is_x2 && qei_step && !up);
    cov_tmr_match: cover property (@(posedge clk_i) disable iff (rst_i) tmr_step && wrap_evt);
    cov_idx: cover property (@(posedge clk_i) disable iff (rst_i) idx_reset);

endmodule

// File: inc/qec_defs.svh
`ifndef QEC_DEFS_SVH
`define QEC_DEFS_SVH

// ==========================================================
// Register byte addresses on the Wishbone slave
`define QEC_ADR_CTRL 8'h00
`define QEC_ADR_FILT 8'h04
`define QEC_ADR_POS 8'h08
`define QEC_ADR_MAX 8'h0c
`define QEC_ADR_STAT 8'h10

// ==========================================================
// Field positions
`define QEC_CTRL_DIR_BIT 11
`define QEC_CTRL_MODE_HI 10
`define QEC_CTRL_MODE_LO 8
`define QEC_CTRL_DSRC_BIT 0
`define QEC_FILT_OUTEN_BIT 7
`define QEC_FILT_DIV_HI 6
`define QEC_FILT_DIV_LO 4
`define QEC_STAT_FLAG_BIT 0
`define QEC_STAT_DIR_BIT 1

// ==========================================================
// Reset values
`define QEC_CTRL_RST 16'h0000
`define QEC_FILT_RST 16'h0000
`define QEC_POS_RST 16'h0000
`define QEC_MAX_RST 16'hffff

// ==========================================================
// Mode codes and filter figures
`define QEC_MODE_OFF 3'h0
`define QEC_MODE_TIMER 3'h1
`define QEC_MODE_X2_IDX 3'h4
`define QEC_MODE_X2_MAX 3'h5
`define QEC_MODE_X4_IDX 3'h6
`define QEC_MODE_X4_MAX 3'h7
`define QEC_FILT_STABLE 2'h3

`endif

// File: inc/qec_pkg.sv
package qec_pkg;
    `include "qec_defs.svh"

    // Measurement mode selector
    typedef enum logic [2:0] {
        QEC_OFF = `QEC_MODE_OFF,
        QEC_TIMER = `QEC_MODE_TIMER,
        QEC_X2_IDX = `QEC_MODE_X2_IDX,
        QEC_X2_MAX = `QEC_MODE_X2_MAX,
        QEC_X4_IDX = `QEC_MODE_X4_IDX,
        QEC_X4_MAX = `QEC_MODE_X4_MAX
    } qec_mode_t;
endpackage

// File: test/qec_enc_model.sv
`timescale 1ns/10ps
// ==========================================================
// Incremental encoder with index pulse, driven at clock edges
module qec_enc_model (
    input wire logic clk_i, // Pacing clock
    output logic phase_a_o, // Phase A pin
    output logic phase_b_o, // Phase B pin
    output logic index_o // Index pin
);
    logic [1:0] gray_q; // Quadrature state 00,10,11,01

    // Pins idle low, so no edge is seen at start-up
    initial begin
        gray_q = 2'h0;
        phase_a_o = 1'b0;
        phase_b_o = 1'b0;
        index_o = 1'b0;
    end

    // Holds the pins past the sync stages and a three-tick filter
    task automatic settle();
        repeat (8) @(posedge clk_i);
    endtask

    // One quadrature step; forward keeps A a quarter turn ahead of B
    task automatic step(input logic fwd);
        @(posedge clk_i);
        gray_q = fwd ? gray_q + 2'h1 : gray_q - 2'h1;
        phase_a_o <= gray_q[1] ^ gray_q[0];
        phase_b_o <= gray_q[1];
        settle();
    endtask

    // One-cycle spike on A, too short for the filter to pass
    task automatic glitch_a();
        @(posedge clk_i);
        phase_a_o <= ~(gray_q[1] ^ gray_q[0]);
        @(posedge clk_i);
        phase_a_o <= gray_q[1] ^ gray_q[0];
        settle();
    endtask

    // Index pulse, wide enough to survive the filter
    task automatic idx_pulse();
        @(posedge clk_i);
        index_o <= 1'b1;
        settle();
        index_o <= 1'b0;
        settle();
    endtask

    // Timer clock pulse on A: low first, so a rise is seen even when A was
    // left high; B is set as the direction level well before the rise
    task automatic tick(input logic b);
        @(posedge clk_i);
        phase_a_o <= 1'b0;
        phase_b_o <= b;
        settle();
        phase_a_o <= 1'b1;
        settle();
    endtask
endmodule

// File: test/qec_top_tb.sv
`timescale 1ns/10ps
`include "qec_defs.svh"
// ==========================================================
// Bench for the encoder counter over classic Wishbone
module qec_top_tb;
    logic clk_i; // 200 MHz clock
    logic rst_i; // Sync reset
    logic ce_i; // Clock enable, dropped once to check the freeze
    logic sleep_i; // Sleep request
    logic por_bor_i; // Power event
    logic [7:0] adr_i;
    logic [31:0] dat_i;
    logic [3:0] sel_i;
    logic we_i;
    logic cyc_i;
    logic stb_i;
    logic [31:0] dat_o;
    logic ack_o;
    logic match_flag_o;
    logic [15:0] position_o;
    logic pa, pb, ix; // Encoder pins
    logic [31:0] rq; // Last read data
    int mismatches = 0;
    int checks_done = 0;

    // Idle levels at time zero, before the first clock edge
    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        ce_i = 1'b1;
        sleep_i = 1'b0;
        por_bor_i = 1'b0;
        adr_i = 8'h00;
        dat_i = 32'h0;
        sel_i = 4'h0;
        we_i = 1'b0;
        cyc_i = 1'b0;
        stb_i = 1'b0;
    end

    always #2.5 clk_i = ~clk_i;

    qec_enc_model i_enc (.clk_i(clk_i), .phase_a_o(pa), .phase_b_o(pb), .index_o(ix));

    qec_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .sleep_i(sleep_i),
        .por_bor_i(por_bor_i), .phase_a_in_i(pa), .phase_b_in_i(pb), .index_in_i(ix),
        .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .match_flag_o(match_flag_o),
        .position_o(position_o));

    // ==========================================================
    // Verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One compare for every value seen
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // ==========================================================
    // Classic cycle; request held until ack is sampled high
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        adr_i <= a;
        we_i <= w;
        dat_i <= d;
        sel_i <= 4'h3;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rq = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            $display("BAD ack expected 1 seen 0");
            final_report();
        end
        // Keeps the strobe low for a cycle between requests
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(a, 1'b1, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        wb(a, 1'b0, 32'h0);
        chk(nm, e, rq);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(`QEC_ADR_CTRL, 32'h0, "ctrl");
        rdchk(`QEC_ADR_FILT, 32'h0, "filt");
        rdchk(`QEC_ADR_POS, 32'h0, "pos");
        rdchk(`QEC_ADR_MAX, 32'hffff, "max");
        wr(8'h14, 32'hffff);
        rdchk(8'h14, 32'h0, "unmapped");
        // x4 with max reset
        wr(`QEC_ADR_CTRL, 32'h0700);
        rdchk(`QEC_ADR_CTRL, 32'h0700, "ctrl");
        repeat (5) i_enc.step(1'b1);
        rdchk(`QEC_ADR_POS, 32'h5, "pos");
        repeat (2) i_enc.step(1'b0);
        rdchk(`QEC_ADR_POS, 32'h3, "pos");
        wr(`QEC_ADR_MAX, 32'h4);
        repeat (2) i_enc.step(1'b1);
        rdchk(`QEC_ADR_POS, 32'h0, "pos");
        i_enc.step(1'b0);
        rdchk(`QEC_ADR_POS, 32'h4, "pos");
        // Sleep freezes the count
        @(posedge clk_i);
        sleep_i <= 1'b1;
        repeat (2) i_enc.step(1'b1);
        chk("position_o", 32'h4, {16'h0, position_o});
        sleep_i <= 1'b0;
        // x4 with index reset
        wr(`QEC_ADR_MAX, 32'hffff);
        wr(`QEC_ADR_CTRL, 32'h0600);
        i_enc.step(1'b1);
        rdchk(`QEC_ADR_POS, 32'h5, "pos");
        i_enc.idx_pulse();
        rdchk(`QEC_ADR_POS, 32'h0, "pos");
        // x2 modes: only A edges count
        wr(`QEC_ADR_CTRL, 32'h0500);
        repeat (4) i_enc.step(1'b1);
        rdchk(`QEC_ADR_POS, 32'h2, "pos");
        repeat (2) i_enc.step(1'b0);
        rdchk(`QEC_ADR_POS, 32'h1, "pos");
        wr(`QEC_ADR_MAX, 32'h1);
        repeat (2) i_enc.step(1'b1);
        rdchk(`QEC_ADR_POS, 32'h0, "pos");
        wr(`QEC_ADR_CTRL, 32'h0400);
        repeat (2) i_enc.step(1'b1);
        i_enc.idx_pulse();
        rdchk(`QEC_ADR_POS, 32'h0, "pos");
        // Filter rejects a spike, passes a real step
        wr(`QEC_ADR_CTRL, 32'h0700);
        wr(`QEC_ADR_MAX, 32'hffff);
        wr(`QEC_ADR_POS, 32'h10);
        wr(`QEC_ADR_FILT, 32'h0080);
        i_enc.glitch_a();
        rdchk(`QEC_ADR_POS, 32'h10, "pos");
        i_enc.step(1'b1);
        rdchk(`QEC_ADR_POS, 32'h11, "pos");
        wr(`QEC_ADR_FILT, 32'h00a0);
        rdchk(`QEC_ADR_FILT, 32'h00a0, "filt");
        @(posedge clk_i);
        por_bor_i <= 1'b1;
        @(posedge clk_i);
        por_bor_i <= 1'b0;
        rdchk(`QEC_ADR_FILT, 32'h0, "filt");
        // Timer mode; switching keeps the count
        wr(`QEC_ADR_CTRL, 32'h0900);
        i_enc.tick(1'b0);
        rdchk(`QEC_ADR_POS, 32'h12, "pos");
        wr(`QEC_ADR_POS, 32'h0);
        wr(`QEC_ADR_MAX, 32'h2);
        repeat (2) i_enc.tick(1'b0);
        chk("match_flag_o", 32'h0, {31'h0, match_flag_o});
        i_enc.tick(1'b0);
        rdchk(`QEC_ADR_POS, 32'h0, "pos");
        chk("match_flag_o", 32'h1, {31'h0, match_flag_o});
        wr(`QEC_ADR_STAT, 32'h1);
        chk("match_flag_o", 32'h0, {31'h0, match_flag_o});
        wr(`QEC_ADR_CTRL, 32'h0100);
        i_enc.tick(1'b1);
        rdchk(`QEC_ADR_POS, 32'h2, "pos");
        wr(`QEC_ADR_CTRL, 32'h0101);
        i_enc.tick(1'b1);
        rdchk(`QEC_ADR_POS, 32'h0, "pos");
        i_enc.tick(1'b0);
        rdchk(`QEC_ADR_POS, 32'h2, "pos");
        @(posedge clk_i);
        sleep_i <= 1'b1;
        i_enc.tick(1'b1);
        chk("position_o", 32'h2, {16'h0, position_o});
        // Clock enable low freezes everything, then counting resumes
        @(posedge clk_i);
        sleep_i <= 1'b0;
        ce_i <= 1'b0;
        i_enc.tick(1'b0);
        chk("position_o", 32'h2, {16'h0, position_o});
        ce_i <= 1'b1;
        i_enc.tick(1'b0);
        rdchk(`QEC_ADR_POS, 32'h1, "pos");
        // Flag still set from the down wraps, last direction down
        rdchk(`QEC_ADR_STAT, 32'h1, "stat");
        final_report();
    end
endmodule
